//--- verilog/completion_straddle_delineation.sv
// Behaviour
// - new packet may share a beat only after one ended at dword 3 or lower
// - straddling needs the straddle parameter and dword-aligned mode
// - while straddling, keep is all ones and last is held at zero
// - first start marker raised whenever any packet begins in the beat
// - with nothing carried over, the first packet starts at byte lane 0
// - after a carried packet ends, the new packet starts at byte lane 16
// - second start marker when two packets begin, at bytes 0 and 16
// - first end marker bit 0 flags an end, bits 3:1 give final dword
// - with two ends, first end offset names earlier packet, range 0 to 3
// - second end marker flags second end, offset only 6 or 7
// - second start implies first start and end; second end implies first end
// - no second packet in a beat whose ending packet carries discontinue
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module completion_straddle_delineation #(
    parameter bit COMPLETION_STRADDLE_PARAM = 1'b1,
    parameter bit DWORD_ALIGNED_MODE        = 1'b1
) (
    // clock and reset
    input  wire logic                                          clk_i,
    input  wire logic                                          rst_n_i,
    // completion source, one half-beat segment at a time
    input  wire cpl_straddle_pkg::seg_s                        seg_i,
    input  wire logic                                          seg_valid_i,
    output logic                                               seg_ready_o,
    // completion stream toward the client
    output logic [cpl_straddle_pkg::DATA_W-1:0]                completion_stream_data_o,
    output cpl_straddle_pkg::user_s                            completion_stream_user_bus_o,
    output logic [cpl_straddle_pkg::KEEP_W-1:0]                completion_stream_keep_o,
    output logic                                               completion_stream_last_o,
    output logic                                               completion_stream_valid_o,
    input  wire logic                                          completion_stream_ready_i,
    // register port
    input  wire logic [cpl_straddle_pkg::REG_ADDR_W-1:0]       reg_addr_i,
    input  wire logic [cpl_straddle_pkg::REG_DATA_W-1:0]       reg_wdata_i,
    input  wire logic                                          reg_wr_i,
    input  wire logic                                          reg_rd_i,
    output logic [cpl_straddle_pkg::REG_DATA_W-1:0]            reg_rdata_o,
    // interrupt
    output logic                                               irq_o
);
    import cpl_straddle_pkg::*;

    function automatic logic [7:0] keep_upto(input logic [2:0] last_dw);
        keep_upto = KEEP_ALL >> (LAST_DW - last_dw);
    endfunction : keep_upto

    // ============================================================
    // framing state
    fill_e              fill_reg,       fill_next;
    seg_s               low_reg,        low_next;
    logic               open_reg,       open_next;
    logic [DATA_W-1:0]  data_reg,       data_next;
    user_s              user_reg,       user_next;
    logic [KEEP_W-1:0]  keep_reg,       keep_next;
    logic               last_reg,       last_next;
    logic               valid_reg,      valid_next;
    logic               up_start_reg,   up_start_next;
    logic               low_disc_reg,   low_disc_next;
    logic               low_start_reg,  low_start_next;
    logic               beat_strad_reg, beat_strad_next;
    // ============================================================
    // register state
    logic [EVT_W-1:0]      status_reg, status_next;
    logic [EVT_W-1:0]      mask_reg,   mask_next;
    logic                  ctrl_reg,   ctrl_next;
    logic [REG_DATA_W-1:0] rdata_reg,  rdata_next;
    logic                  irq_reg,    irq_next;

    logic             straddle_ok;
    logic             slot_free;
    logic             pairable;
    logic             emit_pair;
    logic             emit_low;
    logic             accept;
    seg_s             up;
    logic [2:0]       up_off;
    logic [EVT_W-1:0] evt;

    assign straddle_ok = COMPLETION_STRADDLE_PARAM && DWORD_ALIGNED_MODE && ctrl_reg;
    assign slot_free   = !valid_reg || completion_stream_ready_i;
    // an upper-half start needs a low half that closed its packet cleanly
    assign pairable    = seg_i.sop ? (straddle_ok && low_reg.eop
                                      && !low_reg.discontinue)
                                   : !low_reg.eop;

    // ============================================================
    // segment packing and beat build
    always_comb begin
        fill_next       = fill_reg;
        low_next        = low_reg;
        open_next       = open_reg;
        data_next       = data_reg;
        user_next       = user_reg;
        keep_next       = keep_reg;
        last_next       = last_reg;
        valid_next      = valid_reg;
        up_start_next   = up_start_reg;
        low_disc_next   = low_disc_reg;
        low_start_next  = low_start_reg;
        beat_strad_next = beat_strad_reg;
        seg_ready_o     = 1'b0;
        emit_pair       = 1'b0;
        emit_low        = 1'b0;
        evt             = '0;
        up              = '0;
        up_off          = UPPER_DW_BASE;
        if (valid_reg && completion_stream_ready_i) begin
            valid_next    = 1'b0;
            user_next     = '0;
            up_start_next = 1'b0;
            low_start_next = 1'b0;
            low_disc_next = 1'b0;
        end
        unique case (fill_reg)
            FILL_EMPTY: begin
                seg_ready_o = 1'b1;
                if (seg_valid_i) begin
                    low_next  = seg_i;
                    fill_next = FILL_LOW;
                end
            end
            FILL_LOW: begin
                if (seg_valid_i && slot_free) begin
                    seg_ready_o = 1'b1;
                    if (pairable) begin
                        emit_pair = 1'b1;
                        fill_next = FILL_EMPTY;
                    end else begin
                        emit_low = 1'b1;
                        low_next = seg_i;
                    end
                end else if (!seg_valid_i && low_reg.eop && slot_free) begin
                    // flush a finished low half rather than wait for a partner
                    emit_low  = 1'b1;
                    fill_next = FILL_EMPTY;
                end
            end
        endcase
        accept = seg_valid_i && seg_ready_o;
        if (accept) begin
            open_next = !seg_i.eop;
            evt[EVT_FRAME_ERR] = (seg_i.sop == open_reg);
        end
        if (emit_pair) begin
            up = seg_i;
        end
        up_off = UPPER_DW_BASE | {1'b0, up.end_dw};
        if (emit_pair || emit_low) begin
            valid_next      = 1'b1;
            data_next       = {up.data, low_reg.data};
            user_next       = '0;
            user_next.byte_en = {up.byte_en, low_reg.byte_en};
            user_next.first_start_marker  = low_reg.sop || up.sop;
            user_next.second_start_marker = low_reg.sop && up.sop;
            if (low_reg.eop) begin
                user_next.first_end_marker = {1'b0, low_reg.end_dw, 1'b1};
            end else if (up.eop) begin
                user_next.first_end_marker = {up_off, 1'b1};
            end
            if (low_reg.eop && up.eop) begin
                user_next.second_end_marker = {up_off, 1'b1};
            end
            user_next.discontinue = (low_reg.eop && low_reg.discontinue)
                                    || (up.eop && up.discontinue);
            if (straddle_ok) begin
                keep_next = KEEP_ALL;
                last_next = 1'b0;
            end else if (low_reg.eop) begin
                keep_next = keep_upto({1'b0, low_reg.end_dw});
                last_next = 1'b1;
            end else begin
                keep_next = up.eop ? keep_upto(up_off) : (emit_pair ? KEEP_ALL : KEEP_LOW);
                last_next = up.eop;
            end
            // low half always holds the packet at lane 0; upper starts sit at lane 16
            low_start_next  = low_reg.sop;
            up_start_next   = up.sop;
            low_disc_next   = low_reg.eop && low_reg.discontinue;
            beat_strad_next = straddle_ok;
            evt[EVT_DISC]     = user_next.discontinue;
            evt[EVT_STRADDLE] = up.sop;
        end
    end

    // ============================================================
    // register port and interrupt
    always_comb begin
        status_next = status_reg;
        mask_next   = mask_reg;
        ctrl_next   = ctrl_reg;
        rdata_next  = '0;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                ADDR_STATUS: status_next = status_reg & ~reg_wdata_i[EVT_W-1:0];
                ADDR_MASK:   mask_next   = reg_wdata_i[EVT_W-1:0];
                ADDR_CTRL:   ctrl_next   = reg_wdata_i[CTRL_STRADDLE_BIT];
                default:     ;
            endcase
        end
        // a new event beats a clear in the same cycle
        status_next = status_next | evt;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_STATUS: rdata_next = {{(REG_DATA_W-EVT_W){1'b0}}, status_reg};
                ADDR_MASK:   rdata_next = {{(REG_DATA_W-EVT_W){1'b0}}, mask_reg};
                ADDR_CTRL:   rdata_next = {{(REG_DATA_W-1){1'b0}}, ctrl_reg};
                default:     rdata_next = '0;
            endcase
        end
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fill_reg       <= FILL_EMPTY;
            low_reg        <= '0;
            open_reg       <= 1'b0;
            data_reg       <= '0;
            user_reg       <= '0;
            keep_reg       <= '0;
            last_reg       <= 1'b0;
            valid_reg      <= 1'b0;
            up_start_reg   <= 1'b0;
            low_disc_reg   <= 1'b0;
            low_start_reg  <= 1'b0;
            beat_strad_reg <= 1'b0;
            status_reg     <= STATUS_RST;
            mask_reg       <= MASK_RST;
            ctrl_reg       <= CTRL_RST;
            rdata_reg      <= '0;
            irq_reg        <= 1'b0;
        end else begin
            fill_reg       <= fill_next;
            low_reg        <= low_next;
            open_reg       <= open_next;
            data_reg       <= data_next;
            user_reg       <= user_next;
            keep_reg       <= keep_next;
            last_reg       <= last_next;
            valid_reg      <= valid_next;
            up_start_reg   <= up_start_next;
            low_disc_reg   <= low_disc_next;
            low_start_reg  <= low_start_next;
            beat_strad_reg <= beat_strad_next;
            status_reg     <= status_next;
            mask_reg       <= mask_next;
            ctrl_reg       <= ctrl_next;
            rdata_reg      <= rdata_next;
            irq_reg        <= irq_next;
        end
    end

    assign completion_stream_data_o     = data_reg;
    assign completion_stream_user_bus_o = user_reg;
    assign completion_stream_keep_o     = keep_reg;
    assign completion_stream_last_o     = last_reg;
    assign completion_stream_valid_o    = valid_reg;
    assign reg_rdata_o                  = rdata_reg;
    assign irq_o                        = irq_reg;

    // ============================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_keep_last_fixed: assert property (valid_reg && beat_strad_reg |->
        keep_reg == KEEP_ALL && !last_reg) else $error("keep or last moved while straddling");
    a_markers_idle: assert property (!valid_reg |->
        !user_reg.first_start_marker && !user_reg.second_start_marker
        && !user_reg.first_end_marker[0] && !user_reg.second_end_marker[0])
        else $error("marker active without valid");
    a_start_marked: assert property (valid_reg && (low_start_reg || up_start_reg) |->
        user_reg.first_start_marker) else $error("start not marked");
    a_second_start_deps: assert property (user_reg.second_start_marker |->
        user_reg.first_start_marker && user_reg.first_end_marker[0])
        else $error("second start without first start and end");
    a_second_end_deps: assert property (user_reg.second_end_marker[0] |->
        user_reg.first_end_marker[0] && user_reg.first_end_marker[3:1] <= LOW_MAX_DW)
        else $error("second end without early first end");
    a_second_end_range: assert property (user_reg.second_end_marker[0] |->
        user_reg.second_end_marker[3:2] == 2'h3) else $error("second end offset below six");
    a_upper_start_end: assert property (valid_reg && up_start_reg |->
        user_reg.first_end_marker[0] && user_reg.first_end_marker[3:1] <= LOW_MAX_DW)
        else $error("upper start without low-half end");
    a_no_disc_straddle: assert property (valid_reg && low_disc_reg |->
        !up_start_reg && user_reg.discontinue) else $error("packet started after discontinue");
    a_straddle_gated: assert property (valid_reg && !beat_strad_reg |->
        !up_start_reg && !user_reg.second_start_marker) else $error("straddle while disabled");
    a_stall_holds: assert property (valid_reg && !completion_stream_ready_i |=>
        valid_reg && $stable(data_reg) && $stable(user_reg)) else $error("beat changed under stall");
    a_irq_level: assert property (irq_reg == |(status_reg & mask_reg))
        else $error("interrupt level disagrees with status");

    c_two_starts: cover property (valid_reg && user_reg.second_start_marker);
    c_two_ends: cover property (valid_reg && user_reg.second_end_marker[0]);
    c_disc_beat: cover property (valid_reg && user_reg.discontinue);
    c_stall: cover property (valid_reg && !completion_stream_ready_i ##1 completion_stream_ready_i);

endmodule : completion_straddle_delineation

`default_nettype wire

//--- pkg/cpl_straddle_pkg.sv
`default_nettype none
// ============================================================
// completion straddle framer constants and carriers
package cpl_straddle_pkg;

    localparam int DATA_W      = 256;
    localparam int SEG_W       = 128;
    localparam int BE_W        = 32;
    localparam int SEG_BE_W    = 16;
    localparam int KEEP_W      = 8;
    localparam int REG_ADDR_W  = 4;
    localparam int REG_DATA_W  = 32;

    // ============================================================
    // register map, byte addresses
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK   = 4'h4;
    localparam logic [3:0] ADDR_CTRL   = 4'h8;

    // ============================================================
    // event bits, shared by status and mask
    localparam int         EVT_W         = 3;
    localparam int         EVT_DISC      = 0;
    localparam int         EVT_STRADDLE  = 1;
    localparam int         EVT_FRAME_ERR = 2;
    localparam logic [2:0] STATUS_RST    = 3'h0;
    localparam logic [2:0] MASK_RST      = 3'h0;

    // ============================================================
    // control register
    localparam int   CTRL_STRADDLE_BIT = 0;
    localparam logic CTRL_RST          = 1'b1;

    // ============================================================
    // beat layout
    localparam logic [2:0] UPPER_DW_BASE = 3'h4;
    localparam logic [2:0] LAST_DW       = 3'h7;
    localparam logic [2:0] LOW_MAX_DW    = 3'h3;
    localparam logic [7:0] KEEP_ALL      = 8'hFF;
    localparam logic [7:0] KEEP_LOW      = 8'h0F;

    typedef enum logic {
        FILL_EMPTY = 1'b0,
        FILL_LOW   = 1'b1
    } fill_e;

    // one 4-dword half of a beat from the completion source
    typedef struct packed {
        logic [127:0] data;
        logic [15:0]  byte_en;
        logic         sop;
        logic         eop;
        logic [1:0]   end_dw;
        logic         discontinue;
    } seg_s;

    // sideband user bus, bit 42 down to bit 0
    typedef struct packed {
        logic        discontinue;
        logic [3:0]  second_end_marker;
        logic [3:0]  first_end_marker;
        logic        second_start_marker;
        logic        first_start_marker;
        logic [31:0] byte_en;
    } user_s;

endpackage : cpl_straddle_pkg

`default_nettype wire

//--- tb/cpl_client_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// client side: consumes straddled completion beats
module cpl_client_model (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // completion stream from the device
    input  wire logic [255:0]            data_i,
    input  wire cpl_straddle_pkg::user_s user_i,
    input  wire logic [7:0]              keep_i,
    input  wire logic                    last_i,
    input  wire logic                    valid_i,
    output logic                         ready_o,
    // control and observation
    input  wire logic                    stall_en_i,
    output logic [15:0]                  beat_cnt_o,
    output logic [15:0]                  pkt_cnt_o,
    output logic [15:0]                  drop_cnt_o,
    output logic [15:0]                  byte_cnt_o,
    output logic [15:0]                  bad_cnt_o,
    output cpl_straddle_pkg::user_s      last_user_o,
    output cpl_straddle_pkg::user_s      prev_user_o,
    output logic [255:0]                 last_data_o,
    output logic [7:0]                   last_keep_o,
    output logic                         last_last_o
);
    import cpl_straddle_pkg::*;
    int         seed = 32'h5A17;
    logic [1:0] ends;
    logic       odd;
    assign ends = user_i.first_end_marker[0] + user_i.second_end_marker[0];
    // marker set that no device may show in straddle mode
    assign odd = (user_i.second_start_marker
                  && !(user_i.first_start_marker && user_i.first_end_marker[0]))
                 || (user_i.second_end_marker[0] && !user_i.first_end_marker[0])
                 || keep_i != 8'hFF || last_i;
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            ready_o    <= 1'b1;
            beat_cnt_o <= '0;
            pkt_cnt_o  <= '0;
            drop_cnt_o <= '0;
            byte_cnt_o <= '0;
            bad_cnt_o  <= '0;
        end else begin
            // a slow client stalls at random when asked to
            ready_o <= stall_en_i ? 1'($random(seed)) : 1'b1;
            if (valid_i && ready_o) begin
                beat_cnt_o  <= beat_cnt_o + 16'h1;
                prev_user_o <= last_user_o;
                last_user_o <= user_i;
                last_data_o <= data_i;
                last_keep_o <= keep_i;
                last_last_o <= last_i;
                byte_cnt_o  <= byte_cnt_o + 16'($countones(user_i.byte_en));
                pkt_cnt_o   <= pkt_cnt_o + 16'(ends) - 16'(user_i.discontinue);
                drop_cnt_o  <= drop_cnt_o + 16'(user_i.discontinue);
                bad_cnt_o   <= bad_cnt_o + 16'(odd);
            end
        end
    end
endmodule : cpl_client_model
`default_nettype wire

//--- tb/completion_straddle_delineation_tb.sv
`timescale 1ns/10ps
`default_nettype none
module completion_straddle_delineation_tb;
    import cpl_straddle_pkg::*;
    logic         clk_i = 1'b0;
    logic         rst_n_i = 1'b0;
    seg_s         seg_i = '0;
    logic         seg_valid_i = 1'b0;
    logic         seg_ready_o, last_o, valid_o, ready_i, irq_o, last_last;
    logic [255:0] data_o, last_data;
    user_s        user_o, last_user, prev_user;
    logic [7:0]   keep_o, last_keep;
    logic [3:0]   reg_addr_i = '0;
    logic [31:0]  reg_wdata_i = '0;
    logic         reg_wr_i = 1'b0;
    logic         reg_rd_i = 1'b0;
    logic [31:0]  reg_rdata_o;
    logic         stall_en = 1'b0;
    logic [15:0]  beat_cnt, pkt_cnt, drop_cnt, byte_cnt, bad_cnt;
    int           num_errors = 0;
    int           checks = 0;
    int           cycles = 0;
    int           seed = 32'hd527;

    completion_straddle_delineation i_completion_straddle_delineation (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .seg_i(seg_i), .seg_valid_i(seg_valid_i),
        .seg_ready_o(seg_ready_o), .completion_stream_data_o(data_o),
        .completion_stream_user_bus_o(user_o), .completion_stream_keep_o(keep_o),
        .completion_stream_last_o(last_o), .completion_stream_valid_o(valid_o),
        .completion_stream_ready_i(ready_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
    cpl_client_model i_cpl_client_model (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .data_i(data_o), .user_i(user_o),
        .keep_i(keep_o), .last_i(last_o), .valid_i(valid_o), .ready_o(ready_i),
        .stall_en_i(stall_en), .beat_cnt_o(beat_cnt), .pkt_cnt_o(pkt_cnt),
        .drop_cnt_o(drop_cnt), .byte_cnt_o(byte_cnt), .bad_cnt_o(bad_cnt),
        .last_user_o(last_user), .prev_user_o(prev_user), .last_data_o(last_data),
        .last_keep_o(last_keep), .last_last_o(last_last));

    // ============================================================
    // clock, hang guard, reporting
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors = num_errors + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    // ============================================================
    // register port and segment drivers, all aligned to rising edges
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : reg_write
    task automatic rd_check(input logic [3:0] a, input logic [31:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        check(reg_rdata_o, exp);
        @(posedge clk_i);
    endtask : rd_check
    // ready is combinational, so it is judged settled at the falling edge
    task automatic send_seg(input seg_s s);
        seg_i <= s;
        seg_valid_i <= 1'b1;
        do @(negedge clk_i); while (seg_ready_o !== 1'b1);
        @(posedge clk_i);
    endtask : send_seg
    task automatic seg_idle();
        seg_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask : seg_idle
    task automatic wait_beat(input logic [15:0] target);
        for (int k = 0; k < 300 && beat_cnt !== target; k++) @(negedge clk_i);
        check(beat_cnt, target);
        @(posedge clk_i);
    endtask : wait_beat
    function automatic seg_s mk(input logic sop, eop, input logic [1:0] dw, input logic dc);
        seg_s s;
        s.data = {$random(seed), $random(seed), $random(seed), $random(seed)};
        s.byte_en = 16'($random(seed));
        s.sop = sop;
        s.eop = eop;
        s.end_dw = dw;
        s.discontinue = dc;
        return s;
    endfunction : mk
    function automatic user_s eu(input logic fs, ss, input logic [3:0] fe, se,
                                 input logic dc, input logic [31:0] be);
        return {dc, se, fe, ss, fs, be};
    endfunction : eu

    // ============================================================
    // main sequence
    initial begin : main
        seg_s        a, b;
        logic [15:0] base, p0, d0, b0;
        int          good, drop, bytes, nseg, r;
        good = 0;
        drop = 0;
        bytes = 0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd_check(ADDR_STATUS, 32'h0);
        rd_check(ADDR_MASK, 32'h0);
        rd_check(ADDR_CTRL, 32'h1);
        reg_write(4'hC, 32'hFFFFFFFF);
        rd_check(4'hC, 32'h0);
        // stray end with no open packet raises the framing event
        base = beat_cnt;
        send_seg(mk(1'b0, 1'b1, 2'h0, 1'b0));
        seg_idle();
        wait_beat(base + 16'h1);
        rd_check(ADDR_STATUS, 32'h4);
        reg_write(ADDR_STATUS, 32'h4);
        rd_check(ADDR_STATUS, 32'h0);
        // aborted packet must not share its beat with the next one
        base = beat_cnt;
        a = mk(1'b1, 1'b1, 2'h1, 1'b1);
        b = mk(1'b1, 1'b1, 2'h0, 1'b0);
        send_seg(a);
        send_seg(b);
        seg_idle();
        wait_beat(base + 16'h2);
        check(prev_user, eu(1'b1, 1'b0, 4'h3, 4'h0, 1'b1, {16'h0, a.byte_en}));
        check(last_user, eu(1'b1, 1'b0, 4'h1, 4'h0, 1'b0, {16'h0, b.byte_en}));
        check(last_data[127:0], b.data);
        rd_check(ADDR_STATUS, 32'h1);
        @(negedge clk_i);
        check(irq_o, 1'b0);
        @(posedge clk_i);
        reg_write(ADDR_MASK, 32'h2);
        // two whole packets in one beat
        base = beat_cnt;
        a = mk(1'b1, 1'b1, 2'h0, 1'b0);
        b = mk(1'b1, 1'b1, 2'h2, 1'b0);
        send_seg(a);
        send_seg(b);
        seg_idle();
        wait_beat(base + 16'h1);
        check(last_user, eu(1'b1, 1'b1, 4'h1, 4'hD, 1'b0, {b.byte_en, a.byte_en}));
        check(last_user.second_start_marker, 1'b1);
        check(last_user.second_end_marker, 4'hD);
        check(last_data, {b.data, a.data});
        check(last_keep, 8'hFF);
        check(last_last, 1'b0);
        @(negedge clk_i);
        check(valid_o, 1'b0);
        check(user_o, '0);
        check(irq_o, 1'b1);
        @(posedge clk_i);
        rd_check(ADDR_STATUS, 32'h3);
        reg_write(ADDR_STATUS, 32'h3);
        @(negedge clk_i);
        check(irq_o, 1'b0);
        @(posedge clk_i);
        // carried packet ends at dword 3, next one starts at lane 16
        base = beat_cnt;
        send_seg(mk(1'b1, 1'b0, 2'h0, 1'b0));
        send_seg(mk(1'b0, 1'b0, 2'h0, 1'b0));
        a = mk(1'b0, 1'b1, 2'h3, 1'b0);
        b = mk(1'b1, 1'b1, 2'h3, 1'b0);
        send_seg(a);
        send_seg(b);
        seg_idle();
        wait_beat(base + 16'h2);
        check(last_user, eu(1'b1, 1'b0, 4'h7, 4'hF, 1'b0, {b.byte_en, a.byte_en}));
        check(last_user.first_end_marker, 4'h7);
        check(last_user.second_end_marker, 4'hF);
        check(last_data[255:128], b.data);
        // random traffic against a stalling client
        p0 = pkt_cnt;
        d0 = drop_cnt;
        b0 = byte_cnt;
        stall_en <= 1'b1;
        for (int p = 0; p < 60; p++) begin
            r = $random(seed);
            nseg = 1 + r[1:0] % 3;
            for (int i = 0; i < nseg; i++) begin
                // a lone segment carries the descriptor, so it ends at dword 2 or 3
                a = mk(i == 0, i == nseg - 1, 2'($random(seed)) | {nseg == 1, 1'b0},
                       i == nseg - 1 && r[4:2] == 3'h0);
                bytes += $countones(a.byte_en);
                send_seg(a);
            end
            if (a.discontinue) drop++;
            else good++;
            if (r[5]) seg_idle();
        end
        seg_idle();
        for (int k = 0; k < 500 && pkt_cnt + drop_cnt !== p0 + d0 + 16'(good + drop); k++) begin
            @(negedge clk_i);
        end
        @(posedge clk_i);
        check(pkt_cnt - p0, 16'(good));
        check(drop_cnt - d0, 16'(drop));
        check(byte_cnt - b0, 16'(bytes));
        check(bad_cnt, 16'h0);
        stall_en <= 1'b0;
        rd_check(ADDR_STATUS, 32'h2 | 32'(drop != 0));
        reg_write(ADDR_STATUS, 32'h7);
        // straddle switched off: ordinary keep and last framing
        reg_write(ADDR_CTRL, 32'h0);
        rd_check(ADDR_CTRL, 32'h0);
        base = beat_cnt;
        send_seg(mk(1'b1, 1'b1, 2'h1, 1'b0));
        seg_idle();
        wait_beat(base + 16'h1);
        check(last_keep, 8'h03);
        check(last_last, 1'b1);
        print_verdict();
    end
endmodule : completion_straddle_delineation_tb
`default_nettype wire
